// file: hdl/swl_act_pkg.sv
package swl_act_pkg;
  // Reference clock rate
  localparam int unsigned CLK_HZ = 40_000_000;
  // Resume give-up time, earliest legal point, in ms
  localparam int unsigned RESUME_ABANDON_MS = 1;
  localparam int unsigned RESUME_ABANDON_CYCLES = RESUME_ABANDON_MS * (CLK_HZ / 1000);
  // Longest legal resume give-up time, in ms
  localparam int unsigned RESUME_ABANDON_MAX_MS = 100;
  localparam int unsigned RESUME_ABANDON_MAX_CYCLES = RESUME_ABANDON_MAX_MS * (CLK_HZ / 1000);
  // Quiet time after a sync frame before activation counts as complete, in ms
  localparam int unsigned SYNC_QUIET_MS = 5;
  localparam int unsigned SYNC_QUIET_CYCLES = SYNC_QUIET_MS * (CLK_HZ / 1000);
  // Line held low this long means the deactivated state, in us
  localparam int unsigned DEACT_LOW_US = 10;
  localparam int unsigned DEACT_LOW_CYCLES = DEACT_LOW_US * (CLK_HZ / 1_000_000);
  // Counter widths
  localparam int unsigned WAIT_CNT_W = 18;
  localparam int unsigned LOW_CNT_W = 9;
  // Activation states, one-hot
  typedef enum logic [6:0] {
    ST_DEACT = 7'h01,
    ST_RESUME = 7'h02,
    ST_INHIBIT = 7'h04,
    ST_SYNC_TX = 7'h08,
    ST_WAIT_MASTER = 7'h10,
    ST_READY_TX = 7'h20,
    ST_ACTIVE = 7'h40
  } act_state_type;
endpackage : swl_act_pkg

// file: hdl/line_sync_edge.sv
`timescale 1ns/1ps
// Two-stage synchroniser with rise and fall detection on the settled copy
module line_sync_edge (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic lineIn,
  output logic lineLevel,
  output logic lineRise,
  output logic lineFall
);
  logic stage1; // Metastable stage, read only by stage2
  logic stage2; // Settled level
  logic stage3; // Previous settled level for edges

  // Shift chain; constants only under reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else begin
      stage1 <= lineIn;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  assign lineLevel = stage2;
  assign lineRise = stage2 & ~stage3;
  assign lineFall = ~stage2 & stage3;
endmodule : line_sync_edge

// file: hdl/single_wire_link_activation.sv
`timescale 1ns/1ps
module single_wire_link_activation #(
  // Timing counts; the bench shortens both to keep runs brief
  parameter int unsigned RESUME_ABANDON_CYCLES = swl_act_pkg::RESUME_ABANDON_CYCLES,
  parameter int unsigned SYNC_QUIET_CYCLES = swl_act_pkg::SYNC_QUIET_CYCLES
) (
  // Clock and power-on reset
  input wire logic ref_clk,
  input wire logic rst,
  // Line level straight from the pin, not yet synchronised
  input wire logic masterVoltageSignal,
  // Bit and frame layer, same clock
  input wire logic masterActivated,
  input wire logic rxFrameValid,
  input wire logic rxFrameCorrupt,
  input wire logic rxPowerMode,
  input wire logic repeatRequestBit,
  input wire logic txDone,
  input wire logic txBit,
  input wire logic linkResetCommand,
  // Deliberately inert: other interfaces never reach the link state
  input wire logic otherIfReset,
  // Current drive and framer requests
  output logic slaveCurrentSignal,
  output logic txSyncReq,
  output logic txReadyReq,
  // Status for the upper layers
  output logic omitInfo,
  output logic linkActive,
  output logic linkInhibited,
  output logic llcReset
);
  swl_act_pkg::act_state_type state; // Activation state
  swl_act_pkg::act_state_type next_state; // Next activation state
  logic [swl_act_pkg::WAIT_CNT_W-1:0] waitCnt; // Resume and quiet timer
  logic [swl_act_pkg::LOW_CNT_W-1:0] lowCnt; // Line-low duration
  logic reactivated; // Set once a deactivation has been seen
  logic lineLevel; // Synchronised voltage signal
  logic lineRise; // Low-to-high transition
  logic lineDeact; // Line low long enough to be deactivated
  logic resumeExpired; // Resume not answered in time
  logic quietExpired; // No master frame after sync
  logic goodFrame; // Correct power mode frame received
  logic inDeact; // Decoded states
  logic inResume;
  logic inWaitMaster;
  logic inActive;
  logic drawNow; // Current to draw this cycle

  // Pin passes two flops before any logic sees it
  line_sync_edge u_line (
    .ref_clk(ref_clk),
    .rst(rst),
    .lineIn(masterVoltageSignal),
    .lineLevel(lineLevel),
    .lineRise(lineRise),
    .lineFall()
  );

  // State decodes
  assign inDeact = (state == swl_act_pkg::ST_DEACT);
  assign inResume = (state == swl_act_pkg::ST_RESUME);
  assign inWaitMaster = (state == swl_act_pkg::ST_WAIT_MASTER);
  assign inActive = (state == swl_act_pkg::ST_ACTIVE);

  // Timing decodes
  assign lineDeact = (lowCnt == swl_act_pkg::LOW_CNT_W'(swl_act_pkg::DEACT_LOW_CYCLES));
  assign resumeExpired = inResume && (waitCnt >= swl_act_pkg::WAIT_CNT_W'(RESUME_ABANDON_CYCLES - 1));
  assign quietExpired = inWaitMaster && (waitCnt >= swl_act_pkg::WAIT_CNT_W'(SYNC_QUIET_CYCLES - 1));
  // Corrupted frames never qualify, so they draw no reply
  assign goodFrame = rxFrameValid && !rxFrameCorrupt && rxPowerMode;

  // Frame requests are levels held until the framer reports done
  assign txSyncReq = (state == swl_act_pkg::ST_SYNC_TX);
  assign txReadyReq = (state == swl_act_pkg::ST_READY_TX);
  assign linkInhibited = (state == swl_act_pkg::ST_INHIBIT);
  assign linkActive = inActive;
  assign omitInfo = reactivated;

  // Current drawn: wakeup during resume, framer bits once activated
  assign drawNow = lineLevel && (inResume || (!inDeact && !linkInhibited && txBit));

  // Next-state logic; deactivation overrides everything
  always_comb begin
    next_state = state;
    if (lineDeact && !inDeact) begin
      next_state = swl_act_pkg::ST_DEACT;
    end else begin
      case (state)
        swl_act_pkg::ST_DEACT: begin
          // Only a rising line starts the sequence
          if (lineRise) next_state = swl_act_pkg::ST_RESUME;
        end
        swl_act_pkg::ST_RESUME: begin
          if (masterActivated) next_state = swl_act_pkg::ST_SYNC_TX;
          else if (resumeExpired) next_state = swl_act_pkg::ST_INHIBIT;
        end
        swl_act_pkg::ST_INHIBIT: begin
          // Deaf until the line is deactivated
          next_state = swl_act_pkg::ST_INHIBIT;
        end
        swl_act_pkg::ST_SYNC_TX: begin
          if (txDone) next_state = swl_act_pkg::ST_WAIT_MASTER;
        end
        swl_act_pkg::ST_WAIT_MASTER: begin
          if (goodFrame && repeatRequestBit) next_state = swl_act_pkg::ST_SYNC_TX;
          else if (goodFrame) next_state = swl_act_pkg::ST_READY_TX;
          else if (quietExpired) next_state = swl_act_pkg::ST_ACTIVE;
        end
        swl_act_pkg::ST_READY_TX: begin
          if (txDone) next_state = swl_act_pkg::ST_ACTIVE;
        end
        swl_act_pkg::ST_ACTIVE: begin
          next_state = swl_act_pkg::ST_ACTIVE;
        end
        default: begin
          next_state = swl_act_pkg::ST_DEACT;
        end
      endcase
    end
  end

  // State register; only the power-on reset clears it, never other interfaces
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) state <= swl_act_pkg::ST_DEACT;
    else state <= next_state;
  end

  // Timer restarts on every state change
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) waitCnt <= '0;
    else if (next_state != state) waitCnt <= '0;
    else if (waitCnt != '1) waitCnt <= waitCnt + 1'b1;
  end

  // Line-low duration, saturating at the deactivation threshold
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) lowCnt <= '0;
    else if (lineLevel) lowCnt <= '0;
    else if (!lineDeact) lowCnt <= lowCnt + 1'b1;
  end

  // Later activations follow a deactivation and drop the info field
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) reactivated <= 1'b0;
    else if (lineDeact && !inDeact) reactivated <= 1'b1;
  end

  // Registered current drive
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) slaveCurrentSignal <= 1'b0;
    else slaveCurrentSignal <= drawNow;
  end

  // Link reset goes only to this link's upper layer, nowhere else
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) llcReset <= 1'b0;
    else llcReset <= linkResetCommand && inActive;
  end

  // Checks
  // Every property below is off while rst is high. At the first edges after
  // release the outputs sit at their reset values, which leaves every check met.
  // Properties watch only what this block drives or decodes; the partner's
  // own duties are kept by the stimulus, not asserted here.

  // Steps of a sync frame: held until the framer is done, then the card listens
  sequence syncInFlight;
    txSyncReq && !txDone && !lineDeact;
  endsequence

  sequence syncFinished;
    txSyncReq && txDone && !lineDeact;
  endsequence

  sequence masterAwaited;
    inWaitMaster && !txSyncReq && !txReadyReq;
  endsequence

  // The sync frame request never drops before its completion pulse
  chk_sync_held: assert property (@(posedge ref_clk) disable iff (rst)
    syncInFlight |=> txSyncReq)
    else $error("sync request dropped before done");

  // After the sync frame the card waits for the master
  chk_sync_then_wait: assert property (@(posedge ref_clk) disable iff (rst)
    syncFinished |=> masterAwaited)
    else $error("card did not wait after sync frame");

  // The master's activation is answered with a sync request at once
  chk_activation_syncs: assert property (@(posedge ref_clk) disable iff (rst)
    (inResume && masterActivated && !lineDeact) |=> txSyncReq)
    else $error("activation did not request sync frame");

  // Resume shows as current drawn while the line is high
  chk_resume_draws: assert property (@(posedge ref_clk) disable iff (rst)
    (inResume && lineLevel) |=> slaveCurrentSignal)
    else $error("resume drew no current");

  // Ready frame gone completes activation
  chk_ready_completes: assert property (@(posedge ref_clk) disable iff (rst)
    (txReadyReq && txDone && !lineDeact) |=> linkActive)
    else $error("ready frame did not complete activation");

  // Link reset reaches this link's upper layer
  chk_llc_reset_local: assert property (@(posedge ref_clk) disable iff (rst)
    (linkResetCommand && inActive) |=> llcReset)
    else $error("link reset not passed on");

  // And only from an activated link
  chk_llc_only_active: assert property (@(posedge ref_clk) disable iff (rst)
    llcReset |-> $past(inActive) && $past(linkResetCommand))
    else $error("link reset passed on while not active");

  // Once set, the info field stays omitted until power-on reset
  chk_omit_sticky: assert property (@(posedge ref_clk) disable iff (rst)
    omitInfo |=> omitInfo)
    else $error("info field omission cleared");

  // A long low line drops any state back to deactivated
  chk_low_deactivates: assert property (@(posedge ref_clk) disable iff (rst)
    (lineDeact && !inDeact) |=> inDeact && !txSyncReq && !txReadyReq)
    else $error("long low line did not deactivate");

  // The rise follows a long low line, so lineDeact may still be up here
  sequence resumeStarts;
    inDeact && lineRise;
  endsequence

  sequence resumeHolds;
    inResume;
  endsequence

  chk_rise_starts_resume: assert property (@(posedge ref_clk) disable iff (rst)
    resumeStarts |=> resumeHolds)
    else $error("line rise did not start resume");

  // No give-up before the full count has run
  chk_resume_not_early: assert property (@(posedge ref_clk) disable iff (rst)
    (inResume && waitCnt < swl_act_pkg::WAIT_CNT_W'(RESUME_ABANDON_CYCLES - 1)) |=> !linkInhibited)
    else $error("resume abandoned too early");

  // Timer never passes the give-up count, which itself sits under the legal maximum
  chk_resume_not_late: assert property (@(posedge ref_clk) disable iff (rst)
    inResume |-> (waitCnt < swl_act_pkg::WAIT_CNT_W'(RESUME_ABANDON_CYCLES))
      && (RESUME_ABANDON_CYCLES <= swl_act_pkg::RESUME_ABANDON_MAX_CYCLES))
    else $error("resume held past its longest time");

  chk_inhibit_ignores: assert property (@(posedge ref_clk) disable iff (rst)
    (linkInhibited && !lineDeact) |=> linkInhibited && !slaveCurrentSignal)
    else $error("inhibited card reacted to master");

  chk_current_gated: assert property (@(posedge ref_clk) disable iff (rst)
    !lineLevel |=> !slaveCurrentSignal)
    else $error("current drawn while voltage low");

  chk_repeat_resends: assert property (@(posedge ref_clk) disable iff (rst)
    (inWaitMaster && goodFrame && repeatRequestBit && !lineDeact) |=> txSyncReq)
    else $error("repeat request did not resend sync");

  chk_ready_reply: assert property (@(posedge ref_clk) disable iff (rst)
    (inWaitMaster && goodFrame && !repeatRequestBit && !lineDeact) |=> txReadyReq ##0 !txSyncReq)
    else $error("power mode frame not answered with ready");

  chk_corrupt_silent: assert property (@(posedge ref_clk) disable iff (rst)
    (inWaitMaster && rxFrameValid && rxFrameCorrupt && !quietExpired && !lineDeact)
      |=> inWaitMaster && !txSyncReq && !txReadyReq)
    else $error("corrupted frame drew a reply");

  chk_other_reset_inert: assert property (@(posedge ref_clk) disable iff (rst)
    (otherIfReset && inActive && !lineDeact) |=> inActive)
    else $error("other interface reset disturbed link");

  chk_quiet_completes: assert property (@(posedge ref_clk) disable iff (rst)
    (quietExpired && !goodFrame && !lineDeact) |=> linkActive)
    else $error("quiet after sync did not complete activation");

  // The flag follows the deactivation on the very next edge
  chk_reactivation_omits: assert property (@(posedge ref_clk) disable iff (rst)
    (lineDeact && !inDeact) |=> omitInfo)
    else $error("info field not omitted after deactivation");
endmodule : single_wire_link_activation

// file: tb/front_end_model.sv
`timescale 1ns/1ps
// Front-end stand-in: line level, activation pulse, received frames, framer acks
module front_end_model (
  input wire logic ref_clk,
  input wire logic txSyncReq,
  input wire logic txReadyReq,
  output logic masterVoltageSignal,
  output logic masterActivated,
  output logic rxFrameValid,
  output logic rxFrameCorrupt,
  output logic rxPowerMode,
  output logic repeatRequestBit,
  output logic txDone
);
  int txDelay = 0; // Framer latency, set per test for prompt or slow acks
  int txCnt = 0; // Cycles spent on the frame in flight
  // Driven copies start low: line held low until the bench asks for activation
  logic lineQ = 1'b0;
  logic activeQ = 1'b0; // Activation pulse
  logic [3:0] frameQ = 4'h0; // Valid, corrupt, power mode, repeat bit
  logic doneQ = 1'b0; // Framer completion pulse
  assign masterVoltageSignal = lineQ;
  assign masterActivated = activeQ;
  assign {rxFrameValid, rxFrameCorrupt, rxPowerMode, repeatRequestBit} = frameQ;
  assign txDone = doneQ;
  // One completion pulse per request, after txDelay cycles
  always @(negedge ref_clk) begin
    if (doneQ) begin
      doneQ <= 1'b0;
      txCnt <= 0;
    end else if (txSyncReq | txReadyReq) begin
      if (txCnt >= txDelay) doneQ <= 1'b1;
      else txCnt <= txCnt + 1;
    end
  end
  // Rising line activates, low line deactivates before supply goes
  task automatic setLine(input logic v);
    @(negedge ref_clk);
    lineQ = v;
  endtask : setLine
  // Pulse-width coded bits of 200 ns: high for 150 ns on a one, 50 ns on a zero
  task automatic sendBits(input int n);
    int hi;
    for (int b = 0; b < n; b++) begin
      hi = ($urandom_range(0, 1) == 1) ? 6 : 2;
      lineQ = 1'b1;
      repeat (hi) @(negedge ref_clk);
      lineQ = 1'b0;
      repeat (8 - hi) @(negedge ref_clk);
    end
    lineQ = 1'b1;
  endtask : sendBits
  // Master puts the link into the activated state
  task automatic activate();
    @(negedge ref_clk);
    activeQ = 1'b1;
    @(negedge ref_clk);
    activeQ = 1'b0;
  endtask : activate
  // One received frame; qualifiers scrambled once valid drops
  task automatic frame(input logic bad, input logic pm, input logic rep);
    @(negedge ref_clk);
    frameQ = {1'b1, bad, pm, rep};
    @(negedge ref_clk);
    frameQ = {1'b0, ~bad, ~pm, ~rep};
  endtask : frame
endmodule : front_end_model

// file: tb/tb_single_wire_link_activation.sv
`timescale 1ns/1ps
// Self-checking bench: resume, handshake, quiet completion, abandon
module tb_single_wire_link_activation;
  localparam int unsigned ABANDON = 50; // Shortened give-up count
  localparam int unsigned QUIET = 60; // Shortened quiet count
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic txBit = 1'b0;
  logic linkResetCommand = 1'b0;
  logic otherIfReset = 1'b0;
  logic masterVoltageSignal, masterActivated, rxFrameValid, rxFrameCorrupt, rxPowerMode;
  logic repeatRequestBit, txDone, slaveCurrentSignal, txSyncReq, txReadyReq;
  logic omitInfo, linkActive, linkInhibited, llcReset;
  int error_cnt = 0; // Mismatches
  int n_tests = 0; // Comparisons
  int lineUps = 0; // Model: activations since reset
  int reps = 0; // Model: repeat requests this attempt, never above three
  // Reference clock
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  // Other interfaces reset at random all through the run; the link must not notice
  always @(negedge ref_clk) otherIfReset <= 1'($urandom_range(0, 1));
  single_wire_link_activation #(.RESUME_ABANDON_CYCLES(ABANDON), .SYNC_QUIET_CYCLES(QUIET)) DUT (
    .ref_clk(ref_clk), .rst(rst), .masterVoltageSignal(masterVoltageSignal), .masterActivated(masterActivated),
    .rxFrameValid(rxFrameValid), .rxFrameCorrupt(rxFrameCorrupt), .rxPowerMode(rxPowerMode),
    .repeatRequestBit(repeatRequestBit), .txDone(txDone), .txBit(txBit), .linkResetCommand(linkResetCommand),
    .otherIfReset(otherIfReset), .slaveCurrentSignal(slaveCurrentSignal), .txSyncReq(txSyncReq),
    .txReadyReq(txReadyReq), .omitInfo(omitInfo), .linkActive(linkActive), .linkInhibited(linkInhibited),
    .llcReset(llcReset));
  front_end_model fe (
    .ref_clk(ref_clk), .txSyncReq(txSyncReq), .txReadyReq(txReadyReq), .masterVoltageSignal(masterVoltageSignal),
    .masterActivated(masterActivated), .rxFrameValid(rxFrameValid), .rxFrameCorrupt(rxFrameCorrupt),
    .rxPowerMode(rxPowerMode), .repeatRequestBit(repeatRequestBit), .txDone(txDone));
  // Verdict and end of run
  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize
  // Single-bit comparison
  task automatic check(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got %b exp %b", $time, got, exp);
    end
  endtask : check
  // Output selector for the bounded waits
  function automatic logic pick(input int s);
    case (s)
      0: return slaveCurrentSignal;
      1: return txSyncReq;
      2: return txReadyReq;
      3: return linkActive;
      4: return linkInhibited;
      default: return llcReset;
    endcase
  endfunction : pick
  // Bounded wait for an output level; running out ends the run
  task automatic waitFor(input int s, input logic lvl, input int lim);
    int i;
    for (i = 0; i < lim && pick(s) !== lvl; i++) @(negedge ref_clk);
    if (i == lim) begin
      error_cnt++;
      $display("BAD t=%0t wait on output %0d", $time, s);
      summarize();
    end
  endtask : waitFor
  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : idle
  // Raise the line and see the card resume
  task automatic startLink();
    fe.txDelay = $urandom_range(0, 6);
    lineUps++;
    fe.setLine(1'b1);
    waitFor(0, 1'b1, 8);
    check(omitInfo, lineUps > 1);
  endtask : startLink
  // One sync frame requested and sent
  task automatic syncSent();
    waitFor(1, 1'b1, 4);
    waitFor(1, 1'b0, 20);
  endtask : syncSent
  initial begin
    void'($urandom(32'h9C48));
    idle(5);
    rst = 1'b0;
    for (int s = 0; s < 6; s++) check(pick(s), 1'b0);
    check(omitInfo, 1'b0);
    $display("Test reset done");
    startLink();
    fe.activate();
    syncSent();
    fe.frame(1'b1, 1'b1, 1'b0);
    idle(3);
    check(txSyncReq | txReadyReq, 1'b0);
    reps = $urandom_range(1, 3);
    for (int r = 0; r < reps; r++) begin
      fe.frame(1'b0, 1'b1, 1'b1);
      syncSent();
    end
    fe.frame(1'b0, 1'b1, 1'b0);
    waitFor(2, 1'b1, 4);
    waitFor(3, 1'b1, 20);
    idle(2);
    check(linkActive, 1'b1);
    linkResetCommand = 1'b1;
    idle(1);
    linkResetCommand = 1'b0;
    waitFor(5, 1'b1, 4);
    check(linkActive, 1'b1);
    txBit = 1'b1;
    fe.setLine(1'b0);
    idle(4);
    check(slaveCurrentSignal, 1'b0);
    txBit = 1'($urandom_range(0, 1));
    fe.setLine(1'b1);
    idle(4);
    check(slaveCurrentSignal, txBit);
    fe.sendBits(16);
    check(linkActive, 1'b1);
    fe.setLine(1'b0);
    idle(390);
    check(linkActive, 1'b1);
    waitFor(3, 1'b0, 30);
    $display("Test full power activation done");
    startLink();
    fe.activate();
    syncSent();
    idle(QUIET - 10);
    check(linkActive, 1'b0);
    waitFor(3, 1'b1, 20);
    fe.setLine(1'b0);
    waitFor(3, 1'b0, 420);
    $display("Test quiet completion done");
    startLink();
    idle(ABANDON - 10);
    check(linkInhibited, 1'b0);
    waitFor(4, 1'b1, 20);
    idle(2);
    check(slaveCurrentSignal, 1'b0);
    fe.activate();
    fe.frame(1'b0, 1'b1, 1'b0);
    idle(3);
    check(txSyncReq | txReadyReq, 1'b0);
    fe.setLine(1'b0);
    waitFor(4, 1'b0, 420);
    $display("Test abandoned resume done");
    summarize();
  end
endmodule : tb_single_wire_link_activation
